// File: src/mhi_sequencer.sv
/*
 Memory hardware initialization sequencer with an Avalon-MM slave port.
 Writes every selected array, one word per cycle, with the fill pattern and
 matching check bits. Assumes the memories accept a write every cycle.
*/
// Local design decisions: the register addresses and the Avalon-MM slave port.
// Summary of operation
// - Write selected arrays with consistent check bits
// - Start only when global enable set
// - Initialize only memories whose select bit set
// - Bit 0 covers whole data RAM range
// - Bits 2..8 map to peripheral RAMs
// - Unassigned select bits reserved, start nothing
// - Serial port RAMs initialize on reset release
// - Serial port init independent of select bit
`timescale 1ns/10ps
`default_nettype none
module mhi_sequencer
	import mhi_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_port_global_control_zero,
	output logic [NUM_MEM-1:0] init_wr_en,
	output logic [31:0] init_addr,
	output logic [63:0] init_data,
	output logic [7:0] init_check,
	output logic busy,
	output logic done
);
	typedef struct packed {
		mhi_state_e state;
		mhi_mask_t pend;
		logic [3:0] idx;
		logic [31:0] addr;
		logic en;
		mhi_mask_t sel;
		logic global_run;
		logic done;
		logic serial_done;
		logic busy;
		logic ser_prev;
		logic waitreq;
		logic [31:0] rdata;
		mhi_mask_t wr_en;
		logic [31:0] wr_addr;
	} mhi_seq_s;

	mhi_seq_s s_reg;
	mhi_seq_s s_next;
	logic acc;
	logic start_acc;
	logic ser_rise;

	// One wait state: accept only while waitrequest is still high
	assign acc = (avs_read | avs_write) & s_reg.waitreq;
	assign start_acc = acc & avs_write & (avs_address == OFS_ENABLE) & avs_writedata[EN_BIT] & ~s_reg.busy;
	assign ser_rise = serial_port_global_control_zero & ~s_reg.ser_prev;

	always_comb
	begin
		logic [3:0] first;
		mhi_mask_t left;
		first = '0;
		left = '0;
		s_next = s_reg;
		s_next.wr_en = '0;
		s_next.waitreq = 1'b1;
		s_next.rdata = '0;
		s_next.ser_prev = serial_port_global_control_zero;
		// Lowest pending array goes first
		for (int k = NUM_MEM - 1; k >= 0; k--)
			if (s_reg.pend[k])
				first = 4'(k);
		case (s_reg.state)
			MHI_IDLE:
			begin
				if (|s_reg.pend)
				begin
					s_next.idx = first;
					s_next.addr = MEM_BASE[first];
					s_next.state = MHI_RUN;
				end
			end
			MHI_RUN:
			begin
				s_next.wr_en = mhi_mask_t'(9'h001 << s_reg.idx);
				s_next.wr_addr = s_reg.addr;
				if (s_reg.addr == MEM_END[s_reg.idx] - MEM_STEP[s_reg.idx] + 32'h1)
				begin
					left = s_reg.pend & ~mhi_mask_t'(9'h001 << s_reg.idx);
					s_next.pend = left;
					s_next.state = MHI_IDLE;
					if (s_reg.idx == 4'(SERIAL_BIT))
						s_next.serial_done = 1'b1;
					if (left == '0 && s_reg.global_run)
					begin
						s_next.done = 1'b1;
						s_next.global_run = 1'b0;
					end
				end
				else
					s_next.addr = s_reg.addr + MEM_STEP[s_reg.idx];
			end
			default:
				s_next.state = MHI_IDLE;
		endcase
		// Register access; applied after the sequencer so a new request wins
		if (acc)
		begin
			s_next.waitreq = 1'b0;
			if (avs_read)
			begin
				if (avs_address == OFS_ENABLE)
					s_next.rdata = {31'h0, s_reg.en};
				else if (avs_address == OFS_SELECT)
					s_next.rdata = {23'h0, s_reg.sel};
				else if (avs_address == OFS_STATUS)
					s_next.rdata = {29'h0, s_reg.serial_done, s_reg.done, s_reg.busy};
				else
					s_next.rdata = '0;
			end
			else if (avs_address == OFS_ENABLE)
			begin
				s_next.en = avs_writedata[EN_BIT];
				if (start_acc)
				begin
					s_next.pend = s_next.pend | s_reg.sel;
					s_next.global_run = (s_reg.sel != '0);
					s_next.done = (s_reg.sel == '0);
				end
			end
			else if (avs_address == OFS_SELECT && !s_reg.busy)
				s_next.sel = avs_writedata[NUM_MEM-1:0] & SEL_VALID_MASK;
		end
		// Release of the serial port's reset queues its RAMs on its own
		if (ser_rise)
		begin
			s_next.pend[SERIAL_BIT] = 1'b1;
			s_next.serial_done = 1'b0;
		end
		s_next.busy = (s_next.state == MHI_RUN) || (|s_next.pend);
	end

	// State register; waitrequest idles high so no access slips through reset
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.state <= MHI_IDLE;
			s_reg.en <= RST_ENABLE;
			s_reg.sel <= RST_SELECT;
			s_reg.waitreq <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	mhi_checkgen u_checkgen (
		.clock(clock),
		.rst(rst),
		.data(FILL_PATTERN),
		.use_ecc(ECC_MASK[s_reg.idx]),
		.odd(ODD_PARITY_MASK[s_reg.idx]),
		.data_out(init_data),
		.check_out(init_check)
	);

	assign avs_readdata = s_reg.rdata;
	assign avs_waitrequest = s_reg.waitreq;
	assign init_wr_en = s_reg.wr_en;
	assign init_addr = s_reg.wr_addr;
	assign busy = s_reg.busy;
	assign done = s_reg.done;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Checks of the sequencer's own outputs and internal state
	a_start_needs_cause: assert property ((!s_reg.busy && !start_acc && !ser_rise) |=> !s_reg.busy)
		else $error("sequence started without enable or serial release");
	a_only_selected: assert property ((init_wr_en != '0) |->
		((init_wr_en & ~(s_reg.sel | mhi_mask_t'(9'h001 << SERIAL_BIT))) == '0))
		else $error("unselected memory written");
	a_reserved_quiet: assert property ((init_wr_en & ~SEL_VALID_MASK) == '0)
		else $error("reserved select bit produced a write");
	a_one_memory: assert property ((init_wr_en != '0) |-> $onehot(init_wr_en))
		else $error("more than one memory written at once");
	a_ram_range: assert property (init_wr_en[RAM_BIT] |->
		(init_addr >= MEM_BASE[RAM_BIT] && init_addr <= MEM_END[RAM_BIT] && init_addr[2:0] == 3'h0))
		else $error("data RAM write outside its range");
	a_vector_range: assert property (init_wr_en[VECTOR_BIT] |->
		(init_addr >= MEM_BASE[VECTOR_BIT] && init_addr <= MEM_END[VECTOR_BIT]))
		else $error("interrupt vector RAM write outside its range");
	// Words of one array must be contiguous, or a gap would keep stale check bits
	a_addr_steps: assert property ((init_wr_en != '0 && init_wr_en == $past(init_wr_en)) |->
		(init_addr == $past(init_addr) + (init_wr_en[RAM_BIT] ? MEM_STEP[RAM_BIT] : MEM_STEP[SERIAL_BIT])))
		else $error("array words not contiguous");
	a_empty_done: assert property ((start_acc && s_reg.sel == '0) |=> done)
		else $error("empty select did not report done");
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_read_idle: assert property (avs_waitrequest |-> avs_readdata == '0)
		else $error("read data not zero outside an answer");
	a_serial_queued: assert property (ser_rise |=> s_reg.pend[SERIAL_BIT] ##1 s_reg.busy)
		else $error("serial port release did not queue its RAM");
	a_ecc_zero: assert property (init_wr_en[RAM_BIT] |-> (init_check == 8'h00 && init_data == FILL_PATTERN))
		else $error("data RAM check bits inconsistent");
	a_select_frozen: assert property ((acc && avs_write && avs_address == OFS_SELECT && s_reg.busy)
		|=> $stable(s_reg.sel))
		else $error("select changed during a sequence");
	c_global_done: cover property ($rose(done));
	c_serial_run: cover property (ser_rise ##[1:4] init_wr_en[SERIAL_BIT]);
	c_ram_write: cover property (init_wr_en[RAM_BIT]);
	c_select_refused: cover property (acc && avs_write && avs_address == OFS_SELECT && s_reg.busy);
endmodule
`default_nettype wire

// File: src/mhi_pkg.sv
/*
 Constants and types shared by the memory hardware initialization sequencer:
 register offsets, field positions, memory ranges and check-bit settings.
 Assumes a byte-addressed register port with one 32-bit word per register.
*/
package mhi_pkg;
	localparam int NUM_MEM = 9;
	typedef logic [NUM_MEM-1:0] mhi_mask_t;
	typedef enum logic {MHI_IDLE, MHI_RUN} mhi_state_e;

	// Register byte offsets
	localparam logic [3:0] OFS_ENABLE = 4'h0;
	localparam logic [3:0] OFS_SELECT = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;

	// Field positions
	localparam int EN_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_SERIAL_DONE_BIT = 2;

	// Reset values
	localparam logic RST_ENABLE = 1'h0;
	localparam mhi_mask_t RST_SELECT = 9'h000;

	// Select bits with a memory behind them; bit 1 is reserved
	localparam mhi_mask_t SEL_VALID_MASK = 9'h1FD;
	localparam int SERIAL_BIT = 7;
	localparam int RAM_BIT = 0;
	localparam int VECTOR_BIT = 2;

	// Per select bit: first and last byte address of each array
	localparam logic [31:0] MEM_BASE [NUM_MEM] = '{32'h08000000, 32'h00000000, 32'hFFF82000,
		32'hFF460000, 32'hFF4E0000, 32'hFF1E0000, 32'hFF1C0000, 32'hFF0E0000, 32'hFF3E0000};
	localparam logic [31:0] MEM_END [NUM_MEM] = '{32'h08007FFF, 32'h00000003, 32'hFFF82FFF,
		32'hFF47FFFF, 32'hFF4FFFFF, 32'hFF1FFFFF, 32'hFF1DFFFF, 32'hFF0FFFFF, 32'hFF3FFFFF};
	// Data RAM holds 64-bit ECC words, peripheral RAMs 32-bit parity words
	localparam logic [31:0] MEM_STEP [NUM_MEM] = '{32'h8, 32'h4, 32'h4, 32'h4, 32'h4, 32'h4,
		32'h4, 32'h4, 32'h4};
	localparam mhi_mask_t ECC_MASK = 9'h001;
	localparam mhi_mask_t ODD_PARITY_MASK = 9'h000;
	localparam logic [63:0] FILL_PATTERN = 64'h0000000000000000;
endpackage

// File: src/mhi_checkgen.sv
/*
 Check-bit generator: registers the fill word together with its check bits,
 SEC-DED ECC (7 Hamming bits and one overall parity) or one parity bit.
 Assumes the caller aligns its own write strobe with the one-cycle latency.
*/
`timescale 1ns/10ps
`default_nettype none
module mhi_checkgen
	import mhi_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [63:0] data,
	input wire logic use_ecc,
	input wire logic odd,
	output logic [63:0] data_out,
	output logic [7:0] check_out
);
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] check;
	} mhi_cg_s;

	mhi_cg_s s_reg;
	mhi_cg_s s_next;
	logic [6:0] ham;

	// Hamming bit j covers data bits whose position plus one has bit j set
	function automatic logic [63:0] cover_mask(input int j);
		logic [63:0] m;
		m = '0;
		for (int k = 0; k < 64; k++)
			m[k] = 1'(((k + 1) >> j) & 1);
		return m;
	endfunction

	genvar j;
	generate
		for (j = 0; j < 7; j++)
		begin : g_ham
			assign ham[j] = ^(data & cover_mask(j));
		end
	endgenerate

	// Pick the check bits that match the array's own scheme
	always_comb
	begin
		s_next.data = data;
		if (use_ecc)
			s_next.check = {^{data, ham}, ham};
		else
			s_next.check = {7'h00, (^data[31:0]) ^ odd};
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign data_out = s_reg.data;
	assign check_out = s_reg.check;
endmodule
`default_nettype wire

// File: tb/mhi_sequencer_bench.sv
/*
 Self-checking bench for the memory init sequencer.
 Assumes one wait state per register access and all-zero fill words.
*/
`timescale 1ns/10ps
`default_nettype none
module mhi_sequencer_bench;
	logic clock, rst, avs_read, avs_write, avs_waitrequest, busy, done, serial_port_global_control_zero;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, init_addr, first_a, last_a;
	logic [8:0] init_wr_en;
	logic [63:0] init_data;
	logic [7:0] init_check;
	int failures, tests_run, cyc, bad, tot;
	int cnt [9];

	mhi_sequencer u_dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_port_global_control_zero(serial_port_global_control_zero),
		.init_wr_en(init_wr_en), .init_addr(init_addr), .init_data(init_data), .init_check(init_check),
		.busy(busy), .done(done));

	// Free-running 200 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Strobe watcher; also cuts a hang short
	always @(posedge clock)
	begin
		cyc++;
		if (cyc > 50000)
		begin
			failures++;
			end_sim();
		end
		else
		begin
			for (int i = 0; i < 9; i++)
				if (init_wr_en[i] === 1'b1)
				begin
					if (cnt[i] == 0)
						first_a = init_addr;
					else if (init_addr !== last_a + (i == 0 ? 32'h8 : 32'h4))
						bad++;
					// Zero data must carry zero check bits in both schemes
					if ($countones(init_wr_en) != 1 || init_data !== 64'h0 || init_check !== 8'h00)
						bad++;
					last_a = init_addr;
					cnt[i]++;
					tot++;
				end
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic clr_wait();
		repeat (2) @(posedge clock);
		while (busy !== 1'b0)
			@(posedge clock);
		// Last strobe stands with busy low; let the watcher count it first
		@(posedge clock);
	endtask

	task automatic t_reset();
		bus(0, 4'h0, 0); chk("enable", 32'h0, rd);
		bus(0, 4'h4, 0); chk("select", 32'h0, rd);
		bus(0, 4'h8, 0); chk("status", 32'h0, rd);
		bus(0, 4'hC, 0); chk("unmapped", 32'h0, rd);
	endtask

	// Select alone starts nothing; reserved bit alone starts nothing
	task automatic t_reserved();
		bus(1, 4'h4, 32'h0000_0004);
		repeat (20) @(posedge clock);
		chk("no start", 0, tot);
		bus(1, 4'h4, 32'hFFFF_FFFE);
		bus(0, 4'h4, 0); chk("reserved", 32'h0000_01FC, rd);
		bus(1, 4'h4, 32'h0000_0002);
		bus(1, 4'h0, 32'h1);
		clr_wait();
		chk("reserved writes", 0, tot);
	endtask

	// Vector RAM only; select change mid-run is ignored
	task automatic t_vector();
		bus(1, 4'h4, 32'h0000_0004);
		bus(1, 4'h0, 32'h1);
		bus(1, 4'h4, 32'h0000_0001);
		chk("busy pin", 1, busy);
		clr_wait();
		chk("done pin", 1, done);
		chk("vec words", 1024, tot);
		chk("vec count", 1024, cnt[2]);
		chk("vec first", 32'hFFF8_2000, first_a);
		chk("vec last", 32'hFFF8_2FFC, last_a);
		bus(0, 4'h4, 0); chk("frozen", 32'h0000_0004, rd);
		bus(0, 4'h8, 0); chk("done", 32'h2, rd & 32'h3);
	endtask

	task automatic t_data_ram();
		tot = 0;
		bus(1, 4'h4, 32'h0000_0001);
		bus(1, 4'h0, 32'h1);
		clr_wait();
		chk("ram words", 4096, tot);
		chk("ram first", 32'h0800_0000, first_a);
		chk("ram last", 32'h0800_7FF8, last_a);
		chk("check bits", 0, bad);
	endtask

	// Serial release runs its RAM even though bit 7 is not selected
	task automatic t_serial();
		tot = 0;
		bus(1, 4'h0, 32'h0);
		serial_port_global_control_zero <= 1'b1;
		clr_wait();
		chk("ser words", 32768, tot);
		chk("ser first", 32'hFF0E_0000, first_a);
		chk("ser last", 32'hFF0F_FFFC, last_a);
		bus(0, 4'h8, 0); chk("ser done", 32'h4, rd & 32'h4);
		chk("ser check bits", 0, bad);
		chk("done kept", 1, done);
	endtask

	task automatic end_sim();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		{avs_read, avs_write, serial_port_global_control_zero} = 3'h0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_reserved();
		t_vector();
		t_data_ram();
		t_serial();
		end_sim();
	end
endmodule
`default_nettype wire
